/* design/tcs_supervisor.v */
// The APB register port and the register offsets are this design's own decisions.
`include "tcs_regs.vh"

// Functional notes
// - count pairs without correction; active goes passive at passive threshold
// - passive threshold held within 1 to 15 pairs
// - empty minislot advances the slot counter by one
// - dynamic frame starts only in a minislot, may span several
// - dynamic length = minislot length times count, below cycle minus static
// - dynamic frame starts at action point, 1 to 31 macroticks in
// - only static frames carry the netmgmt vector, 0 to 12 bytes
// - no transmission in idle time; clock resync runs there
// - idle time length held within 2 to 805 macroticks
// - count reaching fatal threshold sends active or passive to halt
// - cycle length held within 10 to 16000 macroticks
module tcs_supervisor #(
    parameter SLOTW = 11
) (
    input  wire        clk,
    input  wire        resetn,
    input  wire        clkEn,
    input  wire        mtTick,
    input  wire        pairDone,
    input  wire        corrValid,
    input  wire        dynTxReq,
    input  wire        dynTxBusy,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output reg         txAllowed,
    output reg         dynTxStart,
    output reg         staticPhase,
    output reg  [3:0]  netmgmtVecLen,
    output reg         resyncWindow,
    output reg  [SLOTW-1:0] slotId,
    output wire        irq
);
    reg        enable_r;
    reg [31:0] thresh_r;
    reg [31:0] minislot_r;
    reg [31:0] cycle_r;
    reg [31:0] segment_r;
    reg [31:0] netmgmt_r;
    reg [`TCS_IRQ_W-1:0] irqSt_r;
    reg [`TCS_IRQ_W-1:0] irqMask_r;
    reg [31:0] prdata_r;
    reg        rdAck_r;
    reg [1:0]  pocState_r;
    reg [3:0]  missCnt_r;
    reg [1:0]  phase_r;
    reg [13:0] mtCnt_r;
    reg [5:0]  msCnt_r;
    reg [12:0] msIdx_r;
    reg        frameOn_r;
    reg [1:0]  pocState_nxt;

    wire [3:0]  passThr;
    wire [3:0]  fatThr;
    wire [5:0]  msLen;
    wire [4:0]  actOfs;
    wire [9:0]  idleLen;
    wire [13:0] cycLen;
    wire [3:0]  nmvLen;
    wire [4:0]  fixBits;
    wire        ordErr;

    // range limits on every configured timing field except static length and minislot count
    tcs_clamp #(.W(4)) uPas (
        .value  (thresh_r[`TCS_PAS_LSB +: 4]),
        .lo     (`TCS_THR_MIN),
        .hi     (`TCS_THR_MAX),
        .result (passThr),
        .fixed  (fixBits[0])
    );
    tcs_clamp #(.W(4)) uFat (
        .value  (thresh_r[`TCS_FAT_LSB +: 4]),
        .lo     (`TCS_THR_MIN),
        .hi     (`TCS_THR_MAX),
        .result (fatThr),
        .fixed  (fixBits[1])
    );
    tcs_clamp #(.W(6)) uMsl (
        .value  (minislot_r[`TCS_MSLEN_LSB +: 6]),
        .lo     (`TCS_MSLEN_MIN),
        .hi     (`TCS_MSLEN_MAX),
        .result (msLen),
        .fixed  (fixBits[2])
    );
    tcs_clamp #(.W(5)) uAct (
        .value  (minislot_r[`TCS_ACTOFS_LSB +: 5]),
        .lo     (`TCS_ACTOFS_MIN),
        .hi     (`TCS_ACTOFS_MAX),
        .result (actOfs),
        .fixed  (fixBits[3])
    );
    tcs_clamp #(.W(10)) uIdl (
        .value  (segment_r[`TCS_IDLE_LSB +: 10]),
        .lo     (`TCS_IDLE_MIN),
        .hi     (`TCS_IDLE_MAX),
        .result (idleLen),
        .fixed  (fixBits[4])
    );
    tcs_clamp #(.W(14)) uCyc (
        .value  (cycle_r[13:0]),
        .lo     (`TCS_CYC_MIN),
        .hi     (`TCS_CYC_MAX),
        .result (cycLen),
        .fixed  ()
    );

    // netmgmt vector capped at 12 bytes
    assign nmvLen = (netmgmt_r[3:0] > `TCS_NMV_MAX) ?
                    `TCS_NMV_MAX : netmgmt_r[3:0];
    // threshold order check, software is expected to keep it
    assign ordErr = (passThr > fatThr);

    // segment lengths
    wire [13:0] statLen = segment_r[`TCS_STATLEN_LSB +: 14];
    wire [12:0] numMs   = minislot_r[`TCS_NMSLOT_LSB +: 13];
    wire [18:0] dynLen  = msLen * numMs;
    wire [13:0] nitStart = cycLen - {4'h0, idleLen};
    wire        dynFits = ({5'h00, statLen} + dynLen)
                          < {5'h00, cycLen};
    wire        lastMt  = (mtCnt_r == cycLen - 14'h0001);
    wire        dynEnd  = (mtCnt_r == statLen + dynLen[13:0]);

    // apb: writes complete at once, reads after one wait state
    wire        wrEn = psel & penable & pwrite;
    wire        rdEn = psel & penable & ~pwrite;
    wire        rdTake = rdEn & ~rdAck_r;
    reg         mapped;
    // the wait state lets prdata come straight from a flop
    assign pready  = ~rdEn | rdAck_r;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_r;
    assign irq     = |(irqSt_r & irqMask_r);

    // address decode and read mux
    reg [31:0] rdVal;
    always @* begin
        mapped = 1'b1;
        rdVal  = 32'h0000_0000;
        case (paddr)
            `TCS_CTRL_ADDR:     rdVal = {31'h0, enable_r};
            `TCS_STATUS_ADDR:   rdVal = {22'h0, ordErr, ~dynFits,
                                         phase_r, missCnt_r, pocState_r};
            `TCS_IRQ_ST_ADDR:   rdVal = {28'h0, irqSt_r};
            `TCS_IRQ_MASK_ADDR: rdVal = {28'h0, irqMask_r};
            // reads return the range-limited settings in force
            `TCS_THRESH_ADDR:   rdVal = {20'h0, fatThr, 4'h0, passThr};
            `TCS_MINISLOT_ADDR: rdVal = {3'h0, numMs, 3'h0, actOfs,
                                         2'h0, msLen};
            `TCS_CYCLE_ADDR:    rdVal = {18'h0, cycLen};
            `TCS_SEGMENT_ADDR:  rdVal = {6'h0, idleLen, 2'h0, statLen};
            `TCS_NETMGMT_ADDR:  rdVal = {28'h0, nmvLen};
            `TCS_SLOT_ADDR:     rdVal = {{(32-SLOTW){1'b0}}, slotId};
            default:            mapped = 1'b0;
        endcase
    end

    // register writes and read data capture
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enable_r   <= 1'b0;
            thresh_r   <= `TCS_THRESH_RST;
            minislot_r <= `TCS_MINISLOT_RST;
            cycle_r    <= `TCS_CYCLE_RST;
            segment_r  <= `TCS_SEGMENT_RST;
            netmgmt_r  <= `TCS_NETMGMT_RST;
            irqMask_r  <= {`TCS_IRQ_W{1'b0}};
            prdata_r   <= 32'h0000_0000;
            rdAck_r    <= 1'b0;
        end else if (clkEn) begin
            rdAck_r <= rdTake;
            if (rdTake) begin
                prdata_r <= rdVal;
            end
            if (wrEn) begin
                case (paddr)
                    `TCS_CTRL_ADDR:     enable_r   <= pwdata[`TCS_CTRL_EN_BIT];
                    `TCS_IRQ_MASK_ADDR: irqMask_r  <= pwdata[3:0];
                    `TCS_THRESH_ADDR:   thresh_r   <= pwdata & 32'h0000_0f0f;
                    `TCS_MINISLOT_ADDR: minislot_r <= pwdata & 32'h1fff_1f3f;
                    `TCS_CYCLE_ADDR:    cycle_r    <= pwdata & 32'h0000_3fff;
                    `TCS_SEGMENT_ADDR:  segment_r  <= pwdata & 32'h03ff_3fff;
                    `TCS_NETMGMT_ADDR:  netmgmt_r  <= pwdata & 32'h0000_000f;
                    default: ;
                endcase
            end
        end
    end

    // protocol state: passive and halt thresholds on the pair counter
    always @* begin
        pocState_nxt = pocState_r;
        case (pocState_r)
            `TCS_ST_CONFIG: begin
                if (enable_r) begin
                    pocState_nxt = `TCS_ST_ACTIVE;
                end
            end
            `TCS_ST_ACTIVE: begin
                if (missCnt_r >= fatThr) begin
                    pocState_nxt = `TCS_ST_HALT;
                end else if (missCnt_r >= passThr) begin
                    pocState_nxt = `TCS_ST_PASSIVE;
                end
            end
            `TCS_ST_PASSIVE: begin
                if (missCnt_r >= fatThr) begin
                    pocState_nxt = `TCS_ST_HALT;
                end
            end
            `TCS_ST_HALT: begin
                if (!enable_r) begin
                    pocState_nxt = `TCS_ST_CONFIG;
                end
            end
            default: pocState_nxt = `TCS_ST_CONFIG;
        endcase
        if (!enable_r) begin
            pocState_nxt = `TCS_ST_CONFIG;
        end
    end

    // missing-correction pair counter and state register
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pocState_r <= `TCS_ST_CONFIG;
            missCnt_r  <= 4'h0;
        end else if (clkEn) begin
            pocState_r <= pocState_nxt;
            if (pocState_r == `TCS_ST_CONFIG) begin
                missCnt_r <= 4'h0;
            end else if (pairDone) begin
                if (corrValid) begin
                    missCnt_r <= 4'h0;
                end else if (missCnt_r != 4'hf) begin
                    missCnt_r <= missCnt_r + 4'h1;
                end
            end
        end
    end

    // cycle timebase: static, dynamic, symbol window, idle time
    wire running = (pocState_r == `TCS_ST_ACTIVE) ||
                   (pocState_r == `TCS_ST_PASSIVE);
    wire msLast  = (msCnt_r == msLen - 6'h01);
    // launch decided one macrotick early so it lands on the action point
    wire msAction = (msCnt_r == {1'b0, actOfs} - 6'h01);
    // dynamic numbering restarts from zero; last static id not tracked
    wire [SLOTW-1:0] statLenSlot = {SLOTW{1'b0}};
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mtCnt_r   <= 14'h0000;
            phase_r   <= `TCS_PH_STATIC;
            msCnt_r   <= 6'h00;
            msIdx_r   <= 13'h0000;
            frameOn_r <= 1'b0;
            slotId    <= {SLOTW{1'b0}};
        end else if (clkEn) begin
            if (!running) begin
                mtCnt_r   <= 14'h0000;
                phase_r   <= `TCS_PH_STATIC;
                msCnt_r   <= 6'h00;
                msIdx_r   <= 13'h0000;
                frameOn_r <= 1'b0;
            end else if (mtTick) begin
                mtCnt_r <= lastMt ? 14'h0000 : mtCnt_r + 14'h0001;
                if (lastMt) begin
                    phase_r <= `TCS_PH_STATIC;
                end else if (mtCnt_r == nitStart - 14'h0001) begin
                    phase_r <= `TCS_PH_IDLE;
                end else if (phase_r == `TCS_PH_DYNAMIC && dynEnd) begin
                    phase_r <= `TCS_PH_SYMBOL;
                end else if (phase_r == `TCS_PH_STATIC &&
                             mtCnt_r == statLen - 14'h0001) begin
                    phase_r   <= (numMs != 13'h0000) ?
                                 `TCS_PH_DYNAMIC : `TCS_PH_SYMBOL;
                    msCnt_r   <= 6'h00;
                    msIdx_r   <= 13'h0000;
                    frameOn_r <= 1'b0;
                    // restarts from zero at the start of the dynamic segment
                    slotId <= statLenSlot;
                end
                if (phase_r == `TCS_PH_DYNAMIC) begin
                    msCnt_r <= msLast ? 6'h00 : msCnt_r + 6'h01;
                    if (msAction && dynTxReq && !frameOn_r) begin
                        frameOn_r <= 1'b1;
                    end
                    if (msLast) begin
                        msIdx_r <= msIdx_r + 13'h0001;
                        // a busy frame holds the slot across minislots
                        if (!(frameOn_r && dynTxBusy)) begin
                            slotId    <= slotId + {{(SLOTW-1){1'b0}}, 1'b1};
                            frameOn_r <= 1'b0;
                        end
                    end
                end
            end
        end
    end
    // transmit gating and resync window
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            txAllowed     <= 1'b0;
            dynTxStart    <= 1'b0;
            staticPhase   <= 1'b0;
            netmgmtVecLen <= 4'h0;
            resyncWindow  <= 1'b0;
        end else if (clkEn) begin
            txAllowed    <= running && phase_r != `TCS_PH_IDLE &&
                            phase_r != `TCS_PH_SYMBOL;
            resyncWindow <= running && phase_r == `TCS_PH_IDLE;
            staticPhase  <= running && phase_r == `TCS_PH_STATIC;
            netmgmtVecLen <= (running && phase_r == `TCS_PH_STATIC) ?
                             nmvLen : 4'h0;
            dynTxStart   <= running && mtTick && dynFits &&
                            phase_r == `TCS_PH_DYNAMIC &&
                            msAction && dynTxReq &&
                            !frameOn_r;
        end
    end

    // sticky events: set beats read-clear
    wire [`TCS_IRQ_W-1:0] evt;
    assign evt[`TCS_IRQ_PASSIVE] = clkEn && pocState_r != `TCS_ST_PASSIVE &&
                                   pocState_nxt == `TCS_ST_PASSIVE;
    assign evt[`TCS_IRQ_HALT]    = clkEn && pocState_r != `TCS_ST_HALT &&
                                   pocState_nxt == `TCS_ST_HALT;
    assign evt[`TCS_IRQ_CYCLE]   = clkEn && running && mtTick && lastMt;
    assign evt[`TCS_IRQ_CFGERR]  = ordErr | (|fixBits) | ~dynFits;
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqSt_r <= {`TCS_IRQ_W{1'b0}};
        end else if (clkEn) begin
            if (rdTake && paddr == `TCS_IRQ_ST_ADDR) begin
                irqSt_r <= evt;
            end else begin
                irqSt_r <= irqSt_r | evt;
            end
        end
    end
endmodule // tcs_supervisor

/* design/tcs_regs.vh */
`ifndef TCS_REGS_VH
`define TCS_REGS_VH
// register byte offsets
`define TCS_CTRL_ADDR      12'h000
`define TCS_STATUS_ADDR    12'h004
`define TCS_IRQ_ST_ADDR    12'h008
`define TCS_IRQ_MASK_ADDR  12'h00c
`define TCS_THRESH_ADDR    12'h010
`define TCS_MINISLOT_ADDR  12'h014
`define TCS_CYCLE_ADDR     12'h018
`define TCS_SEGMENT_ADDR   12'h01c
`define TCS_NETMGMT_ADDR   12'h020
`define TCS_SLOT_ADDR      12'h024
// ctrl fields
`define TCS_CTRL_EN_BIT    0
// thresh fields
`define TCS_PAS_LSB        0
`define TCS_FAT_LSB        8
// minislot fields
`define TCS_MSLEN_LSB      0
`define TCS_ACTOFS_LSB     8
`define TCS_NMSLOT_LSB     16
// segment fields
`define TCS_STATLEN_LSB    0
`define TCS_IDLE_LSB       16
// cfg range limits
`define TCS_THR_MIN        4'h1
`define TCS_THR_MAX        4'hf
`define TCS_MSLEN_MIN      6'h02
`define TCS_MSLEN_MAX      6'h3f
`define TCS_ACTOFS_MIN     5'h01
`define TCS_ACTOFS_MAX     5'h1f
`define TCS_NMV_MAX        4'hc
`define TCS_IDLE_MIN       10'h002
`define TCS_IDLE_MAX       10'h325
`define TCS_CYC_MIN        14'h000a
`define TCS_CYC_MAX        14'h3e80
// reset values
`define TCS_THRESH_RST     32'h0000_0f0f
`define TCS_MINISLOT_RST   32'h000a_0204
`define TCS_CYCLE_RST      32'h0000_03e8
`define TCS_SEGMENT_RST    32'h000a_0190
`define TCS_NETMGMT_RST    32'h0000_0000
// protocol states
`define TCS_ST_CONFIG      2'h0
`define TCS_ST_ACTIVE      2'h1
`define TCS_ST_PASSIVE     2'h2
`define TCS_ST_HALT        2'h3
// cycle phases
`define TCS_PH_STATIC      2'h0
`define TCS_PH_DYNAMIC     2'h1
`define TCS_PH_SYMBOL      2'h2
`define TCS_PH_IDLE        2'h3
// irq status bits
`define TCS_IRQ_PASSIVE    0
`define TCS_IRQ_HALT       1
`define TCS_IRQ_CYCLE      2
`define TCS_IRQ_CFGERR     3
`define TCS_IRQ_W          4
`endif

/* design/tcs_clamp.v */
// limits a configuration field to its legal range, flags a fix-up
module tcs_clamp #(
    parameter W = 8
) (
    input  wire [W-1:0] value,
    input  wire [W-1:0] lo,
    input  wire [W-1:0] hi,
    output reg  [W-1:0] result,
    output reg          fixed
);
    // out-of-range values saturate to the nearest bound
    always @* begin
        result = value;
        fixed  = 1'b0;
        if (value < lo) begin
            result = lo;
            fixed  = 1'b1;
        end else if (value > hi) begin
            result = hi;
            fixed  = 1'b1;
        end
    end
endmodule // tcs_clamp

/* testbench/tcs_supervisor_props.sv */
module tcs_supervisor_props #(
    parameter SLOTW = 11
) (
    input wire logic             clk,
    input wire logic             resetn,
    input wire logic             dynTxReq,
    input wire logic             dynTxBusy,
    input wire logic             txAllowed,
    input wire logic             dynTxStart,
    input wire logic             staticPhase,
    input wire logic [3:0]       netmgmtVecLen,
    input wire logic             resyncWindow,
    input wire logic [SLOTW-1:0] slotId
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // phase, launch and slot relations
    a_idle_no_tx: assert property (resyncWindow |-> !txAllowed)
        else $error("send allowed in idle time");
    a_launch_phase: assert property (
        dynTxStart |-> txAllowed && !staticPhase)
        else $error("launch outside dynamic segment");
    a_launch_req: assert property (dynTxStart |-> $past(dynTxReq))
        else $error("launch without pending frame");
    a_launch_pulse: assert property (dynTxStart |=> !dynTxStart)
        else $error("launch longer than one cycle");
    a_nmv_static: assert property (
        !staticPhase |-> netmgmtVecLen == 4'h0)
        else $error("vector length outside static segment");
    a_nmv_range: assert property (netmgmtVecLen <= 4'hc)
        else $error("vector length above twelve");
    a_slot_hold: assert property (
        dynTxBusy && $past(dynTxBusy) && !staticPhase |-> $stable(slotId))
        else $error("slot moved during frame");
    a_slot_step: assert property (
        txAllowed && !staticPhase && $past(txAllowed && !staticPhase)
        && $changed(slotId) |-> slotId == $past(slotId) + 1'b1)
        else $error("slot step not one");

    c_launch: cover property (dynTxStart);
    c_idle: cover property ($rose(resyncWindow));
    c_frame: cover property (dynTxBusy && !staticPhase);
endmodule // tcs_supervisor_props

bind tcs_supervisor tcs_supervisor_props #(.SLOTW(SLOTW)) chk_u (
    .clk(clk), .resetn(resetn), .dynTxReq(dynTxReq),
    .dynTxBusy(dynTxBusy), .txAllowed(txAllowed),
    .dynTxStart(dynTxStart), .staticPhase(staticPhase),
    .netmgmtVecLen(netmgmtVecLen), .resyncWindow(resyncWindow),
    .slotId(slotId));

/* testbench/tcs_node_model.sv */
module tcs_node_model #(
    parameter SLOTW   = 11,
    parameter TICKDIV = 4,
    parameter TARGET  = 2,
    parameter FRAMEMT = 12
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [SLOTW-1:0] slotId,
    input  wire logic             txAllowed,
    input  wire logic             staticPhase,
    input  wire logic             dynTxStart,
    output logic                  mtTick,
    output logic                  dynTxReq,
    output logic                  dynTxBusy
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] divCnt_r;
    logic [7:0] busyCnt_r;
    logic       sent_r;

    // macrotick pulse every TICKDIV clocks
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCnt_r <= 8'h00;
            mtTick   <= 1'b0;
        end else begin
            divCnt_r <= (divCnt_r == TICKDIV - 1) ? 8'h00 : divCnt_r + 8'h01;
            mtTick   <= (divCnt_r == TICKDIV - 1);
        end
    end

    // one frame a cycle; it outlasts a minislot
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sent_r    <= 1'b0;
            busyCnt_r <= 8'h00;
        end else begin
            if (staticPhase) begin
                sent_r <= 1'b0;
            end else if (dynTxStart) begin
                sent_r <= 1'b1;
            end
            if (dynTxStart) begin
                busyCnt_r <= 8'(FRAMEMT);
            end else if (mtTick && busyCnt_r != 8'h00) begin
                busyCnt_r <= busyCnt_r - 8'h01;
            end
        end
    end

    // frame pending only in the chosen dynamic slot
    assign dynTxReq  = txAllowed && !staticPhase && !sent_r
                       && slotId == TARGET;
    assign dynTxBusy = busyCnt_r != 8'h00;
endmodule // tcs_node_model

/* testbench/tb.sv */
`include "tcs_regs.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, resetn, clkEn, pairDone, corrValid;
    logic        psel, penable, pwrite, err, i0;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, txAllowed, dynTxStart, staticPhase;
    wire         resyncWindow, irq, mtTick, dynTxReq, dynTxBusy;
    wire  [3:0]  netmgmtVecLen;
    wire  [10:0] slotId;
    logic [10:0] prev;
    int          failures = 0, checks_done = 0, n, t;
    logic [11:0] tA [9] = '{12'h010, 12'h014, 12'h014, 12'h020, 12'h020,
                            12'h01c, 12'h01c, 12'h018, 12'h018};
    logic [31:0] tW [9] = '{32'h0, 32'h1, 32'h1f3f, 32'hf, 32'h0,
                            32'h10028, 32'h3ff0028, 32'h5, 32'h3fff};
    logic [31:0] tM [9] = '{32'hf0f, 32'h1f3f, 32'h1f3f, 32'hf, 32'hf,
                            32'h3ff3fff, 32'h3ff3fff, 32'h3fff, 32'h3fff};
    logic [31:0] tE [9] = '{32'h101, 32'h102, 32'h1f3f, 32'hc, 32'h0,
                            32'h20028, 32'h3250028, 32'ha, 32'h3e80};
    logic [31:0] rstV [5] = '{`TCS_THRESH_RST, `TCS_MINISLOT_RST,
                 `TCS_CYCLE_RST, `TCS_SEGMENT_RST, `TCS_NETMGMT_RST};

    tcs_supervisor #(.SLOTW(11)) dut_u (
        .clk(clk), .resetn(resetn), .clkEn(clkEn), .mtTick(mtTick),
        .pairDone(pairDone), .corrValid(corrValid), .dynTxReq(dynTxReq),
        .dynTxBusy(dynTxBusy), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .txAllowed(txAllowed),
        .dynTxStart(dynTxStart), .staticPhase(staticPhase),
        .netmgmtVecLen(netmgmtVecLen), .resyncWindow(resyncWindow),
        .slotId(slotId), .irq(irq));
    tcs_node_model #(.SLOTW(11)) node_u (
        .clk(clk), .resetn(resetn), .slotId(slotId),
        .txAllowed(txAllowed), .staticPhase(staticPhase),
        .dynTxStart(dynTxStart), .mtTick(mtTick), .dynTxReq(dynTxReq),
        .dynTxBusy(dynTxBusy));

    // clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic doReset;
        resetn <= 1'b0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
    endtask

    // one apb transfer; response taken at the edge pready is seen high
    task automatic apb(input [11:0] a, input w, input [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        err = pslverr;
        rd  = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle edge lets the effects of the transfer settle
        @(posedge clk);
    endtask

    task automatic pair(input cv);
        @(posedge clk);
        pairDone  <= 1'b1;
        corrValid <= cv;
        @(posedge clk);
        pairDone  <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic testRegs;
        for (int i = 0; i < 5; i++) begin
            apb(12'h010 + 12'(4 * i), 1'b0, 32'h0);
            `CHK(rd, rstV[i])
        end
        `CHK(err, 1'b0)
        apb(12'h030, 1'b0, 32'h0);
        `CHK(err, 1'b1)
        for (int i = 0; i < 9; i++) begin
            apb(tA[i], 1'b1, tW[i]);
            apb(tA[i], 1'b0, 32'h0);
            `CHK(rd & tM[i], tE[i])
        end
        @(posedge clk);
        clkEn <= 1'b0;
        apb(`TCS_NETMGMT_ADDR, 1'b1, 32'h7);
        clkEn <= 1'b1;
        apb(`TCS_NETMGMT_ADDR, 1'b0, 32'h0);
        `CHK(rd, 32'h0)
    endtask

    task automatic testStates;
        apb(`TCS_THRESH_ADDR, 1'b1, 32'h0302);
        apb(`TCS_CTRL_ADDR, 1'b1, 32'h1);
        apb(`TCS_STATUS_ADDR, 1'b0, 32'h0);
        `CHK(rd[1:0], `TCS_ST_ACTIVE)
        pair(1'b0);
        pair(1'b0);
        apb(`TCS_STATUS_ADDR, 1'b0, 32'h0);
        `CHK(rd[1:0], `TCS_ST_PASSIVE)
        apb(`TCS_IRQ_MASK_ADDR, 1'b1, 32'hf);
        i0 = irq;
        apb(`TCS_IRQ_MASK_ADDR, 1'b1, 32'h0);
        `CHK(i0 ^ irq, 1'b1)
        apb(`TCS_IRQ_ST_ADDR, 1'b0, 32'h0);
        `CHK(rd[`TCS_IRQ_PASSIVE], 1'b1)
        apb(`TCS_IRQ_ST_ADDR, 1'b0, 32'h0);
        `CHK(rd[`TCS_IRQ_PASSIVE], 1'b0)
        pair(1'b1);
        apb(`TCS_STATUS_ADDR, 1'b0, 32'h0);
        `CHK(rd[5:2], 4'h0)
        repeat (3) pair(1'b0);
        apb(`TCS_STATUS_ADDR, 1'b0, 32'h0);
        `CHK(rd[1:0], `TCS_ST_HALT)
    endtask

    task automatic testDynamic;
        doReset();
        apb(`TCS_CYCLE_ADDR, 1'b1, 32'd200);
        apb(`TCS_SEGMENT_ADDR, 1'b1, 32'h0050_0028);
        apb(`TCS_MINISLOT_ADDR, 1'b1, 32'h000a_0308);
        apb(`TCS_NETMGMT_ADDR, 1'b1, 32'h5);
        apb(`TCS_CTRL_ADDR, 1'b1, 32'h1);
        n = 0;
        while (staticPhase !== 1'b1 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        `CHK(netmgmtVecLen, 4'h5)
        for (int c = 0; c < 2; c++) begin
            n = 0;
            while (!(txAllowed === 1'b1 && staticPhase === 1'b0) && n < 5000)
            begin
                @(negedge clk);
                n++;
            end
            `CHK(slotId, 11'h000)
        end
        prev = slotId;
        t = 0;
        while (dynTxStart !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
            if (slotId !== prev) begin
                `CHK(slotId, prev + 11'h001)
                prev = slotId;
                t = 0;
            end
            if (mtTick === 1'b1) t++;
        end
        `CHK(slotId, 11'h002)
        `CHK(t, 3)
        repeat (2) @(negedge clk);
        while (dynTxBusy === 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        `CHK(slotId, 11'h002)
        while (resyncWindow !== 1'b1 && n < 9000) begin
            @(negedge clk);
            n++;
        end
        `CHK(txAllowed, 1'b0)
        if (n >= 9000) failures++;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end

    // main sequence
    initial begin
        {clkEn, pairDone, corrValid, psel, penable, pwrite} = 6'h20;
        paddr  = 12'h000;
        pwdata = 32'h0;
        doReset();
        testRegs();
        testStates();
        testDynamic();
        results();
    end
endmodule // tb
